// file: rtl/pstc_pkg.sv
package pstc_pkg;

	// Initialization word one.
	localparam int INIT_WORD_ONE_MARK_BIT     = 4;
	localparam int INIT_WORD_ONE_SINGLE_BIT   = 1;
	localparam int INIT_WORD_ONE_NEED4_BIT    = 0;
	localparam int INIT_WORD_ONE_LEVEL_BIT    = 3;
	// Initialization word four.
	localparam int INIT_WORD_FOUR_X86_BIT      = 0;
	localparam int INIT_WORD_FOUR_AUTO_EOS_BIT = 1;
	localparam int INIT_WORD_FOUR_ROLE_BIT     = 2;
	localparam int INIT_WORD_FOUR_BUF_BIT      = 3;
	localparam int INIT_WORD_FOUR_SFN_BIT      = 4;
	// Operation word three.
	localparam int OPERATION_WORD_THREE_MARK_BIT     = 3;
	localparam int OPERATION_WORD_THREE_RR_BIT       = 1;
	localparam int OPERATION_WORD_THREE_RIS_BIT      = 0;
	localparam int OPERATION_WORD_THREE_POLL_BIT     = 2;
	localparam int OPERATION_WORD_THREE_ESMM_BIT     = 6;
	localparam int OPERATION_WORD_THREE_SMM_BIT      = 5;
	// Operation word two: end-of-service group.
	localparam int OCW2_EOI_BIT      = 5;
	localparam int OCW2_SL_BIT       = 6;

	localparam logic [7:0] MASK_RST    = 8'hFF;
	localparam logic [7:0] ZERO_BYTE   = 8'h00;
	localparam logic [7:0] CALL_OPCODE = 8'hCD;
	localparam logic [2:0] LOWEST_LVL  = 3'h7;

	typedef enum logic [4:0] {
		INIT_IDLE = 5'b00001,
		INIT_W2   = 5'b00010,
		INIT_W3   = 5'b00100,
		INIT_W4   = 5'b01000,
		INIT_DONE = 5'b10000
	} pstc_init_t;

	function automatic logic [2:0] pstc_top_level(input logic [7:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = i[2:0];
			end
		end
		return r;
	endfunction

endpackage

// file: rtl/pstc_ack_if.sv
interface pstc_ack_if;
	logic       ack_fall;
	logic       ack_rise;
	logic       x86_mode;
	logic [1:0] pulse_idx;
	logic       last_pulse;
	modport track (input ack_fall, input ack_rise, input x86_mode, output pulse_idx, output last_pulse);
	modport use_ (output ack_fall, output ack_rise, output x86_mode, input pulse_idx, input last_pulse);
endinterface

// file: rtl/pstc_ack_seq.sv
module pstc_ack_seq (
	input  wire logic   clk_sys,
	input  wire logic   sys_rst,
	pstc_ack_if.track   ack
);
	typedef struct packed {
		logic [1:0] idx;
	} pstc_seq_t;

	pstc_seq_t st_r;
	pstc_seq_t st_nxt;

	// Counts acknowledge pulses; index shows the pulse now in progress or the next one due.
	always_comb begin
		st_nxt = st_r;
		if (ack.ack_rise) begin
			if (ack.last_pulse) begin
				st_nxt.idx = 2'h0;
			end else begin
				st_nxt.idx = st_r.idx + 2'h1;
			end
		end
	end

	assign ack.pulse_idx  = st_r.idx;
	assign ack.last_pulse = ack.x86_mode ? (st_r.idx == 2'h1) : (st_r.idx == 2'h2);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// file: rtl/pstc_edge_sense.sv
module pstc_edge_sense (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic [7:0] req_in,
	input  wire logic       level_mode,
	input  wire logic [7:0] clear_req,
	output logic      [7:0] req_live
);
	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] prev;
		logic [7:0] edge_seen;
	} pstc_es_t;

	pstc_es_t st_r;
	pstc_es_t st_nxt;

	// An edge request stays armed only while the input stays high, so a line that drops early reads as gone.
	always_comb begin
		st_nxt      = st_r;
		st_nxt.s1   = req_in;
		st_nxt.s2   = st_r.s1;
		st_nxt.prev = st_r.s2;
		st_nxt.edge_seen = (st_r.edge_seen & ~clear_req & st_r.s2) | (st_r.s2 & ~st_r.prev); // R07
	end

	assign req_live = level_mode ? st_r.s2 : (st_r.edge_seen & st_r.s2); // R08

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// file: rtl/pstc_top.sv
// Behaviour
// R01 - Read-register command with select low makes reads return the request latch.
// R02 - Read-register command with select high makes reads return the service latch.
// R03 - Last latch selection persists across reads; a poll breaks it.
// R04 - Finishing initialization selects the request latch for status reads.
// R05 - Read with address high returns the mask latch, no command needed.
// R06 - Poll plus read-register flag: next read is a poll, not status.
// R07 - Trigger select low: request only on rising input; held high gives nothing more.
// R08 - Trigger select high: request whenever the input is high.
// R09 - Level source drops its request before end-of-service and re-enable.
// R10 - Source holds request high until first acknowledge pulse falls.
// R11 - Request gone before first acknowledge: answer with lowest level vector.
// R12 - Default lowest-level answer leaves its service bit clear; real one sets it.
// R13 - Special fully nested master forwards higher requests from an in-service slave.
// R14 - Ordinary nested master ignores more requests from a slave in service.
// R15 - Host clears slave, reads its service latch, then clears master if empty.
// R16 - Buffered mode drives buffer enable whenever data drivers are on.
// R17 - Word four bit 3 selects buffered mode, bit 2 the role.
// R18 - Master addresses up to eight slaves on three cascade lines.
// R19 - Selected slave supplies vector bytes two and three, or byte two only.
// R20 - Master holds cascade low when idle, drives address first to last pulse.
// R21 - Host sends end-of-service to both master and the slave concerned.
// R22 - Slave goes on master input zero only after all others are used.
// R23 - Buffered role bit high means master, low slave; ignored unbuffered.
// R24 - Poll byte: top bit marks pending request, low three bits the level.
// R25 - Slave drives vector bytes only when cascade value matches its identity.
module pstc_top (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       cs_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       addr0,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	input  wire logic [7:0] request_input,
	input  wire logic       interrupt_acknowledge_n,
	output logic            int_out,
	input  wire logic [2:0] cas_in,
	output logic      [2:0] cas_out,
	output logic            cas_oe,
	input  wire logic       slave_program_n_in,
	output logic            slave_program_buffer_enable,
	output logic            slave_program_buffer_enable_oe
);
	typedef struct packed {
		logic [2:0]         rd_s;
		logic [2:0]         wr_s;
		logic [2:0]         ack_s;
		logic [1:0]         cs_s;
		logic [1:0]         a0_s;
		logic [7:0]         d1;
		logic [7:0]         d2;
		logic [2:0]         cas1;
		logic [2:0]         cas2;
		logic [1:0]         spn_s;
		pstc_pkg::pstc_init_t init;
		logic               level_mode;
		logic               single;
		logic               need4;
		logic               x86;
		logic               auto_eos;
		logic               buffered;
		logic               role_master;
		logic               sfn;
		logic [4:0]         vec_base;
		logic [7:0]         slave_map;
		logic [2:0]         own_id;
		logic [7:0]         request_latch;
		logic [7:0]         service_latch;
		logic [7:0]         mask_latch;
		logic               sel_service;
		logic               poll_pend;
		logic               ack_live;
		logic               ack_drive;
		logic [2:0]         ack_lvl;
		logic               ack_default;
		logic               ack_cascade;
		logic [7:0]         dout;
		logic               dout_en;
		logic [2:0]         cas_val;
		logic               cas_en;
	} pstc_state_t;

	pstc_state_t st_r;
	pstc_state_t st_nxt;

	logic [7:0] req_live;
	logic [7:0] clear_req;
	logic       rd_fall;
	logic       rd_rise;
	logic       wr_rise;
	logic       is_master;
	logic [7:0] eligible;
	logic [7:0] block_mask;
	logic [2:0] best;
	logic       any_req;
	logic       we_are_target;
	logic       cs_ok;
	logic [7:0] ack_byte;

	pstc_ack_if ack ();

	pstc_edge_sense u_edge (
		.clk_sys    (clk_sys),
		.sys_rst    (sys_rst),
		.req_in     (request_input),
		.level_mode (st_r.level_mode),
		.clear_req  (clear_req),
		.req_live   (req_live)
	);

	pstc_ack_seq u_seq (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.ack     (ack.track)
	);

	// Strobe edges are taken from the settled second and third stages only.
	assign rd_fall = st_r.rd_s[2] & ~st_r.rd_s[1];
	assign rd_rise = ~st_r.rd_s[2] & st_r.rd_s[1];
	assign wr_rise = ~st_r.wr_s[2] & st_r.wr_s[1];
	assign cs_ok   = ~st_r.cs_s[1];
	assign ack.ack_fall = st_r.ack_s[2] & ~st_r.ack_s[1];
	assign ack.ack_rise = ~st_r.ack_s[2] & st_r.ack_s[1];
	assign ack.x86_mode = st_r.x86;

	// Unbuffered parts take the role from the strapped pin; buffered parts from word four.
	assign is_master = st_r.buffered ? st_r.role_master : st_r.spn_s[1]; // R23

	// A slave's in-service line blocks only lower or equal levels; special nesting lets the same slave through again.
	always_comb begin
		block_mask = 8'h00;
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j <= i; j++) begin
				if (st_r.service_latch[j]) begin
					if (!(st_r.sfn && is_master && st_r.slave_map[j] && i == j)) begin // R13
						block_mask[i] = 1'b1; // R14
					end
				end
			end
		end
	end

	// Masked and blocked levels still show in the request latch; the interrupt line, poll byte and acknowledge ignore them.
	assign eligible = st_r.request_latch & ~st_r.mask_latch & ~block_mask;
	assign best     = pstc_pkg::pstc_top_level(eligible);
	assign any_req  = |eligible;
	assign int_out  = any_req & (st_r.init == pstc_pkg::INIT_DONE) & ~st_r.poll_pend;

	// Only a genuine acknowledge disarms the edge latch; a default answer must leave a real edge pending.
	always_comb begin
		clear_req = 8'h00;
		if (st_r.ack_live && ack.ack_fall && !st_r.ack_default) begin
			clear_req[st_r.ack_lvl] = 1'b1;
		end
	end

	// Vector byte for the pulse in progress; the 85 layout splits the routine address over two bytes.
	always_comb begin
		if (st_r.x86) begin
			ack_byte = {st_r.vec_base, st_r.ack_lvl};
		end else if (ack.pulse_idx == 2'h1) begin
			ack_byte = {st_r.vec_base[2:0], st_r.ack_lvl, 2'h0};
		end else begin
			ack_byte = {3'h0, st_r.vec_base};
		end
	end

	// Slave is chosen when cascade matches its identity; a master selects itself for non-slave inputs.
	assign we_are_target = is_master ? !st_r.ack_cascade : (st_r.cas2 == st_r.own_id); // R25

	always_comb begin
		st_nxt = st_r;
		st_nxt.rd_s  = {st_r.rd_s[1:0], rd_n};
		st_nxt.wr_s  = {st_r.wr_s[1:0], wr_n};
		st_nxt.ack_s = {st_r.ack_s[1:0], interrupt_acknowledge_n};
		st_nxt.cs_s  = {st_r.cs_s[0], cs_n};
		st_nxt.a0_s  = {st_r.a0_s[0], addr0};
		st_nxt.d1    = data_in;
		st_nxt.d2    = st_r.d1;
		st_nxt.cas1  = cas_in;
		st_nxt.cas2  = st_r.cas1;
		st_nxt.spn_s = {st_r.spn_s[0], slave_program_n_in};

		// Requests are frozen while a poll waits, so the poll byte and the service bit it sets agree.
		if (!st_r.poll_pend) begin
			st_nxt.request_latch = req_live;
		end

		if (wr_rise && cs_ok) begin
			// Word one restarts initialization from any state; a stray address-low write with bit 4 set drops the setup.
			if (!st_r.a0_s[1] && st_r.d2[pstc_pkg::INIT_WORD_ONE_MARK_BIT]) begin
				st_nxt.init          = pstc_pkg::INIT_W2;
				st_nxt.level_mode    = st_r.d2[pstc_pkg::INIT_WORD_ONE_LEVEL_BIT]; // R07
				st_nxt.single        = st_r.d2[pstc_pkg::INIT_WORD_ONE_SINGLE_BIT];
				st_nxt.need4         = st_r.d2[pstc_pkg::INIT_WORD_ONE_NEED4_BIT];
				st_nxt.mask_latch    = pstc_pkg::ZERO_BYTE;
				st_nxt.service_latch = pstc_pkg::ZERO_BYTE;
				st_nxt.sel_service   = 1'b0; // R04
				st_nxt.poll_pend     = 1'b0;
				st_nxt.x86           = 1'b0;
				st_nxt.auto_eos      = 1'b0;
				st_nxt.buffered      = 1'b0;
				st_nxt.sfn           = 1'b0;
			end else begin
				unique case (st_r.init)
					pstc_pkg::INIT_W2: begin
						st_nxt.vec_base = st_r.d2[7:3];
						if (!st_r.single) begin
							st_nxt.init = pstc_pkg::INIT_W3;
						end else if (st_r.need4) begin
							st_nxt.init = pstc_pkg::INIT_W4;
						end else begin
							st_nxt.init = pstc_pkg::INIT_DONE;
						end
					end
					pstc_pkg::INIT_W3: begin
						st_nxt.slave_map = st_r.d2;
						st_nxt.own_id    = st_r.d2[2:0];
						if (st_r.need4) begin
							st_nxt.init = pstc_pkg::INIT_W4;
						end else begin
							st_nxt.init = pstc_pkg::INIT_DONE;
						end
					end
					pstc_pkg::INIT_W4: begin
						st_nxt.x86         = st_r.d2[pstc_pkg::INIT_WORD_FOUR_X86_BIT];
						st_nxt.auto_eos    = st_r.d2[pstc_pkg::INIT_WORD_FOUR_AUTO_EOS_BIT];
						st_nxt.buffered    = st_r.d2[pstc_pkg::INIT_WORD_FOUR_BUF_BIT]; // R17
						st_nxt.role_master = st_r.d2[pstc_pkg::INIT_WORD_FOUR_ROLE_BIT]; // R17
						st_nxt.sfn         = st_r.d2[pstc_pkg::INIT_WORD_FOUR_SFN_BIT];
						st_nxt.init        = pstc_pkg::INIT_DONE;
					end
					pstc_pkg::INIT_IDLE, pstc_pkg::INIT_DONE: begin
						if (st_r.a0_s[1]) begin
							st_nxt.mask_latch = st_r.d2;
						end else if (st_r.d2[pstc_pkg::OPERATION_WORD_THREE_MARK_BIT]) begin
							if (st_r.d2[pstc_pkg::OPERATION_WORD_THREE_POLL_BIT]) begin
								st_nxt.poll_pend = 1'b1; // R06
							end else if (st_r.d2[pstc_pkg::OPERATION_WORD_THREE_RR_BIT]) begin
								st_nxt.sel_service = st_r.d2[pstc_pkg::OPERATION_WORD_THREE_RIS_BIT]; // R01 R02 R03
							end
						end else if (st_r.d2[pstc_pkg::OCW2_EOI_BIT]) begin
							if (st_r.d2[pstc_pkg::OCW2_SL_BIT]) begin
								st_nxt.service_latch[st_r.d2[2:0]] = 1'b0;
							end else begin
								st_nxt.service_latch[pstc_pkg::pstc_top_level(st_r.service_latch)] = 1'b0;
							end
						end
					end
					default: st_nxt.init = pstc_pkg::INIT_IDLE;
				endcase
			end
		end

		// Register reads; the poll read freezes requests between write and read.
		if (rd_fall && cs_ok) begin
			st_nxt.dout_en = 1'b1;
			if (st_r.poll_pend) begin
				st_nxt.dout = {any_req, 4'h0, best}; // R24
				if (any_req) begin
					st_nxt.service_latch[best] = 1'b1;
				end
			end else if (st_r.a0_s[1]) begin
				st_nxt.dout = st_r.mask_latch; // R05
			end else begin
				st_nxt.dout = st_r.sel_service ? st_r.service_latch : st_r.request_latch; // R01 R02
			end
		end
		// A poll is consumed by the strobe's rising edge, so a read that was cut short still ends it.
		if (rd_rise) begin
			st_nxt.dout_en   = 1'b0;
			st_nxt.poll_pend = 1'b0; // R03
		end

		// Acknowledge sequence.
		// A request that vanished before the first pulse gets the lowest level and no service bit.
		if (ack.ack_fall && ack.pulse_idx == 2'h0) begin
			st_nxt.ack_live    = 1'b1;
			st_nxt.ack_default = !any_req; // R11
			st_nxt.ack_lvl     = any_req ? best : pstc_pkg::LOWEST_LVL; // R11
			st_nxt.ack_cascade = any_req && is_master && !st_r.single && st_r.slave_map[best];
			if (any_req) begin
				st_nxt.service_latch[best] = 1'b1; // R12
			end
		end
		if (ack.ack_fall) begin
			if (ack.pulse_idx == 2'h0 && !st_r.x86) begin
				st_nxt.dout    = pstc_pkg::CALL_OPCODE;
				st_nxt.dout_en = is_master;
			end else if (ack.pulse_idx != 2'h0 && st_r.ack_live) begin
				st_nxt.dout    = ack_byte; // R19
				st_nxt.dout_en = we_are_target; // R25
			end
		end
		// The slave address stands from the first pulse's rising edge to the last, so slaves see it settled.
		if (ack.ack_rise) begin
			st_nxt.dout_en = 1'b0;
			if (ack.pulse_idx == 2'h0 && st_r.ack_cascade) begin
				st_nxt.cas_val = st_r.ack_lvl; // R18 R20
				st_nxt.cas_en  = 1'b1;
			end
			if (ack.last_pulse) begin
				st_nxt.cas_val  = 3'h0; // R20
				st_nxt.ack_live = 1'b0;
				if (st_r.auto_eos && !st_r.ack_default) begin
					st_nxt.service_latch[st_r.ack_lvl] = 1'b0;
				end
			end
		end
		// Only a master drives the cascade lines; a slave listens and must never fight the master.
		if (!is_master) begin
			st_nxt.cas_en = 1'b0;
		end else begin
			st_nxt.cas_en = 1'b1; // R20
		end
	end

	assign data_out = st_r.dout;
	assign data_oe  = st_r.dout_en;
	assign cas_out  = st_r.cas_val;
	assign cas_oe   = st_r.cas_en;
	// In buffered mode the pin is an active-low enable that follows the data drivers.
	assign slave_program_buffer_enable    = ~(st_r.buffered & st_r.dout_en); // R16
	assign slave_program_buffer_enable_oe = st_r.buffered; // R16

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_r            <= '0;
			// Strobe synchronisers reset to the idle high level so no false edge follows reset.
			st_r.rd_s       <= 3'h7;
			st_r.wr_s       <= 3'h7;
			st_r.ack_s      <= 3'h7;
			st_r.cs_s       <= 2'h3;
			st_r.spn_s      <= 2'h3;
			st_r.init       <= pstc_pkg::INIT_IDLE;
			st_r.mask_latch <= pstc_pkg::MASK_RST;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// file: dv/pstc_top_properties.sv
module pstc_top_properties (
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	input wire logic       cs_n,
	input wire logic       rd_n,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic       interrupt_acknowledge_n,
	input wire logic       int_out,
	input wire logic [2:0] cas_out,
	input wire logic       cas_oe,
	input wire logic       slave_program_buffer_enable,
	input wire logic       slave_program_buffer_enable_oe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// Strobes pass through synchronisers, so answers trail the pins by a few cycles.
	sequence s_read_start;
		$fell(rd_n) && !cs_n;
	endsequence
	sequence s_strobes_idle;
		(rd_n && interrupt_acknowledge_n) [*8];
	endsequence
	property p_reset_quiet;
		$fell(sys_rst) |-> !data_oe && !int_out && cas_out == 3'h0;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs active right after reset");
	property p_read_answer;
		s_read_start |-> ##[2:6] data_oe;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read strobe not answered on data bus");
	property p_oe_release;
		s_strobes_idle |-> !data_oe;
	endproperty
	a_oe_release: assert property (p_oe_release)
		else $error("data bus driven with no strobe");
	property p_oe_cause;
		$rose(data_oe) |-> !$past(rd_n, 2) || !$past(interrupt_acknowledge_n, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("data bus enabled without a strobe");
	property p_oe_stands;
		data_oe && !(rd_n && interrupt_acknowledge_n) |=> data_oe;
	endproperty
	a_oe_stands: assert property (p_oe_stands)
		else $error("data bus dropped while strobe low");
	property p_buf_on;
		data_oe && slave_program_buffer_enable_oe |-> !slave_program_buffer_enable;
	endproperty
	a_buf_on: assert property (p_buf_on)
		else $error("buffer enable idle while data bus driven");
	property p_buf_off;
		!data_oe && slave_program_buffer_enable_oe |-> slave_program_buffer_enable;
	endproperty
	a_buf_off: assert property (p_buf_off)
		else $error("buffer enable active while data bus idle");
	property p_cas_quiet;
		!cas_oe |-> cas_out == 3'h0;
	endproperty
	a_cas_quiet: assert property (p_cas_quiet)
		else $error("cascade address while not driving");
endmodule

bind pstc_top pstc_top_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(rd_n),
	.data_out(data_out), .data_oe(data_oe), .interrupt_acknowledge_n(interrupt_acknowledge_n),
	.int_out(int_out), .cas_out(cas_out), .cas_oe(cas_oe), .slave_program_buffer_enable(slave_program_buffer_enable),
	.slave_program_buffer_enable_oe(slave_program_buffer_enable_oe));

// file: dv/pstc_host_model.sv
module pstc_host_model (
	input  wire logic       clk_sys,
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic            addr0,
	output logic      [7:0] data_in,
	output logic            interrupt_acknowledge_n,
	input  wire logic [7:0] data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n = 1'h1;
		rd_n = 1'h1;
		wr_n = 1'h1;
		addr0 = 1'h0;
		data_in = 8'h00;
		interrupt_acknowledge_n = 1'h1;
	end
	// Select stays low after the strobe rises, since the write lands a few cycles later.
	task automatic bus_write(input logic a, input logic [7:0] d);
		@(posedge clk_sys);
		cs_n <= 1'h0;
		addr0 <= a;
		data_in <= d;
		@(posedge clk_sys);
		wr_n <= 1'h0;
		repeat (3) @(posedge clk_sys);
		wr_n <= 1'h1;
		repeat (4) @(posedge clk_sys);
		cs_n <= 1'h1;
		data_in <= ~d;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic bus_read(input logic a, output logic [7:0] v);
		@(posedge clk_sys);
		cs_n <= 1'h0;
		addr0 <= a;
		@(posedge clk_sys);
		rd_n <= 1'h0;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		v = data_out;
		@(posedge clk_sys);
		rd_n <= 1'h1;
		@(posedge clk_sys);
		cs_n <= 1'h1;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic ack_pulse(output logic [7:0] v);
		@(posedge clk_sys);
		interrupt_acknowledge_n <= 1'h0;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		v = data_out;
		@(posedge clk_sys);
		interrupt_acknowledge_n <= 1'h1;
		repeat (6) @(posedge clk_sys);
	endtask
endmodule

// file: dv/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys;
	logic       sys_rst;
	logic       cs_n;
	logic       rd_n;
	logic       wr_n;
	logic       addr0;
	logic [7:0] data_in;
	logic [7:0] data_out;
	logic       data_oe;
	logic [7:0] request_input;
	logic       ack_n;
	logic       int_out;
	logic [2:0] cas_out;
	logic       cas_oe;
	logic       buf_en;
	logic       buf_oe;
	logic [7:0] rd_v;
	int         num_errors = 0;
	int         tests_run = 0;
	// Columns: request lines, word three (zero skips it), mask, expected status read.
	logic [7:0] rows [4][4] = '{'{8'h81, 8'h0A, 8'hF0, 8'h81}, '{8'h3C, 8'h00, 8'h0F, 8'h3C},
		'{8'h3C, 8'h0B, 8'hA5, 8'h00}, '{8'h11, 8'h00, 8'h5A, 8'h00}};

	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end

	pstc_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr0(addr0),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .request_input(request_input),
		.interrupt_acknowledge_n(ack_n), .int_out(int_out), .cas_in(3'h0), .cas_out(cas_out), .cas_oe(cas_oe),
		.slave_program_n_in(1'h1), .slave_program_buffer_enable(buf_en), .slave_program_buffer_enable_oe(buf_oe));
	pstc_host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr0(addr0),
		.data_in(data_in), .interrupt_acknowledge_n(ack_n), .data_out(data_out));

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wait_int(input logic v);
		int n;
		n = 0;
		while (int_out !== v && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
		chk("int_out", {7'h00, int_out}, {7'h00, v});
		if (int_out !== v) test_done();
		@(posedge clk_sys);
	endtask
	// Single unit, 86 vectors, buffered master, all levels unmasked.
	task automatic init_dev(input logic level);
		host.bus_write(1'h0, {4'h1, level, 3'h3});
		host.bus_write(1'h1, 8'h40);
		host.bus_write(1'h1, 8'h0D);
		host.bus_write(1'h1, 8'h00);
	endtask
	task automatic ack_cycle(output logic [7:0] v);
		host.ack_pulse(v);
		host.ack_pulse(v);
	endtask
	// Cascaded buffered master in 86 mode, level sensed, one slave on input two, all levels unmasked.
	task automatic init_cascade(input logic [7:0] word4);
		host.bus_write(1'h0, 8'h19);
		host.bus_write(1'h1, 8'h40);
		host.bus_write(1'h1, 8'h04);
		host.bus_write(1'h1, word4);
		host.bus_write(1'h1, 8'h00);
	endtask

	initial begin
		sys_rst = 1'h1;
		request_input = 8'h00;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'h0;
		repeat (3) @(posedge clk_sys);
		host.bus_read(1'h1, rd_v);
		chk("mask_latch", rd_v, pstc_pkg::MASK_RST);
		$display("test reset done");
		init_dev(1'h1);
		chk("buffer_enable_oe", {7'h00, buf_oe}, 8'h01);
		chk("cas_oe", {7'h00, cas_oe}, 8'h01);
		request_input <= 8'h24;
		host.bus_read(1'h0, rd_v);
		chk("status", rd_v, 8'h24);
		$display("test init done");
		foreach (rows[i]) begin
			request_input <= rows[i][0];
			if (rows[i][1] !== 8'h00) host.bus_write(1'h0, rows[i][1]);
			host.bus_write(1'h1, rows[i][2]);
			host.bus_read(1'h0, rd_v);
			chk("status", rd_v, rows[i][3]);
			host.bus_read(1'h1, rd_v);
			chk("mask_latch", rd_v, rows[i][2]);
		end
		$display("test table done");
		host.bus_write(1'h1, 8'h00);
		request_input <= 8'h30;
		host.bus_write(1'h0, 8'h0E);
		host.bus_read(1'h0, rd_v);
		chk("poll", rd_v, 8'h84);
		host.bus_write(1'h0, 8'h0B);
		host.bus_read(1'h0, rd_v);
		chk("service_latch", rd_v, 8'h10);
		host.bus_write(1'h0, 8'h20);
		$display("test poll done");
		request_input <= 8'h00;
		wait_int(1'h0);
		request_input <= 8'h80;
		wait_int(1'h1);
		ack_cycle(rd_v);
		chk("vector", rd_v, 8'h47);
		host.bus_read(1'h0, rd_v);
		chk("service_latch", rd_v, 8'h80);
		host.bus_write(1'h0, 8'h20);
		host.bus_read(1'h0, rd_v);
		chk("service_latch", rd_v, 8'h00);
		wait_int(1'h1);
		request_input <= 8'h00;
		wait_int(1'h0);
		request_input <= 8'h02;
		wait_int(1'h1);
		// The source lets go before the acknowledge on purpose.
		request_input <= 8'h00;
		repeat (6) @(posedge clk_sys);
		ack_cycle(rd_v);
		chk("vector", rd_v, 8'h47);
		host.bus_read(1'h0, rd_v);
		chk("service_latch", rd_v, 8'h00);
		$display("test level done");
		init_dev(1'h0);
		request_input <= 8'h01;
		wait_int(1'h1);
		ack_cycle(rd_v);
		chk("vector", rd_v, 8'h40);
		host.bus_write(1'h0, 8'h20);
		repeat (30) @(negedge clk_sys);
		chk("int_out", {7'h00, int_out}, 8'h00);
		host.bus_read(1'h0, rd_v);
		chk("request_latch", rd_v, 8'h00);
		$display("test edge done");
		// Word four without and then with special nesting; the slave's line stays high after it is taken.
		for (int k = 0; k < 2; k++) begin
			request_input <= 8'h04;
			init_cascade(k == 0 ? 8'h0D : 8'h1D);
			wait_int(1'h1);
			host.ack_pulse(rd_v);
			@(negedge clk_sys);
			chk("cas_out", {5'h00, cas_out}, 8'h02);
			host.ack_pulse(rd_v);
			@(negedge clk_sys);
			chk("cas_out", {5'h00, cas_out}, 8'h00);
			repeat (10) @(negedge clk_sys);
			chk("int_out", {7'h00, int_out}, {7'h00, k[0]});
			$display("test cascade %0d done", k);
		end
		test_done();
	end
endmodule
